// ---- rrw_pkg.sv ----
// package: constants and carrier types for the receiver reset and serial wake-up block
package rrw_pkg;
    // ********************************************************************
    // clock and time base
    // ********************************************************************
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
    localparam int unsigned POR_MIN_MS = 150;
    localparam int unsigned POR_MAX_MS = 250;
    localparam int unsigned RST_LOW_MIN_MS = 300;
    localparam int unsigned WAKE_MAX_S = 6;
    localparam int unsigned WAKE_PWR_TYP_MS = 3300;
    localparam int unsigned WAKE_EXT_TYP_MS = 3100;
    // the release point used for the power-on reset, inside 150..250 ms
    localparam int unsigned POR_HOLD_MS = 200;
    // ********************************************************************
    // serial port
    // ********************************************************************
    localparam int unsigned SYS_HZ = 71500000;
    localparam int unsigned N_RATES = 7;
    localparam logic [2:0] RATE_4800 = 3'h0;
    localparam logic [2:0] RATE_9600 = 3'h1;
    localparam logic [2:0] RATE_19200 = 3'h2;
    localparam logic [2:0] RATE_38400 = 3'h3;
    localparam logic [2:0] RATE_57600 = 3'h4;
    localparam logic [2:0] RATE_115200 = 3'h5;
    localparam logic [2:0] RATE_230400 = 3'h6;
    localparam logic [2:0] RATE_RESET = RATE_38400;
    localparam int unsigned DIV_W = 16;
    localparam logic [7:0] SENT_START = 8'h24;
    localparam logic [7:0] SENT_END = 8'h0A;

    // status carried out of the sequencer
    typedef struct packed {
        logic por_active;
        logic cpu_in_reset;
        logic tx_live;
        logic rx_live;
    } rrw_status_t;

    // one serial byte with its strobe
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rrw_byte_t;
endpackage

// ---- rrw_uart.sv ----
// file: gated serial port with a divider-derived bit clock
`timescale 1ns/1ps
module rrw_uart (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control from the sequencer
    input wire logic tx_en,
    input wire logic rx_en,
    input wire logic [2:0] rate_sel,
    // transmit side
    input wire rrw_pkg::rrw_byte_t tx_byte,
    output logic tx_ready,
    output logic serial_transmit_line,
    // receive side
    input wire logic rx_line_sync,
    output rrw_pkg::rrw_byte_t rx_byte
);
    // ********************************************************************
    // bit period from a 71.5 MHz count, kept as an integer quotient per rate
    // ********************************************************************
    logic [rrw_pkg::DIV_W-1:0] div;
    always_comb begin
        unique case (rate_sel)
            rrw_pkg::RATE_4800: div = 16'(rrw_pkg::SYS_HZ / 4800);
            rrw_pkg::RATE_9600: div = 16'(rrw_pkg::SYS_HZ / 9600);
            rrw_pkg::RATE_19200: div = 16'(rrw_pkg::SYS_HZ / 19200);
            rrw_pkg::RATE_38400: div = 16'(rrw_pkg::SYS_HZ / 38400);
            rrw_pkg::RATE_57600: div = 16'(rrw_pkg::SYS_HZ / 57600);
            rrw_pkg::RATE_115200: div = 16'(rrw_pkg::SYS_HZ / 115200);
            rrw_pkg::RATE_230400: div = 16'(rrw_pkg::SYS_HZ / 230400);
            default: div = 16'(rrw_pkg::SYS_HZ / 38400);
        endcase
    end
    // the integer divider gives the quantised rates, +0.11 % at the top one
    // the 71.5 MHz tick is made by a fractional accumulator on the 125 MHz clock
    logic [27:0] acc_r, acc_nxt;
    logic sys_tick;
    always_comb begin
        if (acc_r + 28'(rrw_pkg::SYS_HZ) >= 28'(rrw_pkg::CLK_HZ)) begin
            acc_nxt = acc_r + 28'(rrw_pkg::SYS_HZ) - 28'(rrw_pkg::CLK_HZ);
            sys_tick = 1'b1;
        end else begin
            acc_nxt = acc_r + 28'(rrw_pkg::SYS_HZ);
            sys_tick = 1'b0;
        end
    end

    // ********************************************************************
    // transmitter: idle high until enabled
    // ********************************************************************
    logic [15:0] tcnt_r, tcnt_nxt;
    logic [3:0] tbit_r, tbit_nxt;
    logic [9:0] tsh_r, tsh_nxt;
    logic tline_r, tline_nxt;
    assign tx_ready = tx_en && (tbit_r == 4'h0);
    always_comb begin
        tcnt_nxt = tcnt_r;
        tbit_nxt = tbit_r;
        tsh_nxt = tsh_r;
        tline_nxt = tline_r;
        if (!tx_en) begin
            tbit_nxt = 4'h0;
            tline_nxt = 1'b1;
        end else if (tbit_r == 4'h0) begin
            if (tx_byte.valid) begin
                tsh_nxt = {1'b1, tx_byte.data, 1'b0};
                tbit_nxt = 4'hB; // eleventh shift ends a full stop bit
                tcnt_nxt = 16'h0000;
            end
        end else if (sys_tick) begin
            if (tcnt_r == 16'h0000) begin
                tline_nxt = tsh_r[0];
                tsh_nxt = {1'b1, tsh_r[9:1]};
                tbit_nxt = tbit_r - 4'h1;
                tcnt_nxt = div - 16'h0001;
            end else begin
                tcnt_nxt = tcnt_r - 16'h0001;
            end
        end
    end
    // last stop bit still needs its full period before idle
    assign serial_transmit_line = tline_r;

    // ********************************************************************
    // receiver: sampled at mid-bit, ignored while disabled
    // ********************************************************************
    logic [15:0] rcnt_r, rcnt_nxt;
    logic [3:0] rbit_r, rbit_nxt;
    logic [8:0] rsh_r, rsh_nxt;
    rrw_pkg::rrw_byte_t rout_r, rout_nxt;
    always_comb begin
        rcnt_nxt = rcnt_r;
        rbit_nxt = rbit_r;
        rsh_nxt = rsh_r;
        rout_nxt = '{valid: 1'b0, data: rout_r.data};
        if (!rx_en) begin
            rbit_nxt = 4'h0;
        end else if (rbit_r == 4'h0) begin
            if (!rx_line_sync) begin
                rbit_nxt = 4'hA;
                rcnt_nxt = {1'b0, div[15:1]};
            end
        end else if (sys_tick) begin
            if (rcnt_r == 16'h0000) begin
                rcnt_nxt = div - 16'h0001;
                rbit_nxt = rbit_r - 4'h1;
                rsh_nxt = {rx_line_sync, rsh_r[8:1]};
                if (rbit_r == 4'hA && rx_line_sync) begin
                    rbit_nxt = 4'h0; // false start
                end else if (rbit_r == 4'h1 && rx_line_sync) begin
                    rout_nxt = '{valid: 1'b1, data: rsh_r[8:1]};
                end
            end else begin
                rcnt_nxt = rcnt_r - 16'h0001;
            end
        end
    end
    assign rx_byte = rout_r;

    // one register process for the whole port
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            acc_r <= 28'h0000000;
            tcnt_r <= 16'h0000;
            tbit_r <= 4'h0;
            tsh_r <= 10'h3FF;
            tline_r <= 1'b1;
            rcnt_r <= 16'h0000;
            rbit_r <= 4'h0;
            rsh_r <= 9'h000;
            rout_r <= '0;
        end else begin
            acc_r <= acc_nxt;
            tcnt_r <= tcnt_nxt;
            tbit_r <= tbit_nxt;
            tsh_r <= tsh_nxt;
            tline_r <= tline_nxt;
            rcnt_r <= rcnt_nxt;
            rbit_r <= rbit_nxt;
            rsh_r <= rsh_nxt;
            rout_r <= rout_nxt;
        end
    end
endmodule

// ---- rrw_top.sv ----
// file: reset sequencer and serial wake-up control of the timing receiver
// Functional notes
// - power-on reset held 150 to 250 ms
// - reset below falling, valid above rising threshold
// - processor released only when both resets released
// - transmit starts within 6 s of power-up
// - receive ready within 6 s of power-up
// - transmit starts within 6 s of reset release
// - receive ready within 6 s of reset release
// - seven baud rates divided from 71.5 MHz
// - internal reset is low when either low
// - serial port defaults to 38400 after reset
`timescale 1ns/1ps
module rrw_top #(
    parameter int unsigned POR_CYCLES = rrw_pkg::POR_HOLD_MS * rrw_pkg::CLK_PER_MS,
    parameter int unsigned WAKE_PWR_CYCLES = rrw_pkg::WAKE_PWR_TYP_MS * rrw_pkg::CLK_PER_MS,
    parameter int unsigned WAKE_EXT_CYCLES = rrw_pkg::WAKE_EXT_TYP_MS * rrw_pkg::CLK_PER_MS
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // supply comparators, asynchronous
    input wire logic supply_rising_threshold,
    input wire logic supply_falling_threshold,
    // external reset pin, open drain
    input wire logic ext_reset_n_in,
    output logic ext_reset_n_out,
    output logic ext_reset_n_oe,
    // serial pins
    output logic serial_transmit_line,
    input wire logic serial_receive_line,
    // baud selection by command from firmware
    input wire logic rate_load,
    input wire logic [2:0] rate_value,
    // firmware side byte streams
    input wire rrw_pkg::rrw_byte_t tx_byte,
    output logic tx_ready,
    output rrw_pkg::rrw_byte_t rx_byte,
    // status
    output rrw_pkg::rrw_status_t status
);
    // ********************************************************************
    // two-stage synchronisers for all pins
    // ********************************************************************
    // reset values are the idle levels: pin released, supply low, line idle,
    // so no false edge and no early release follows reset
    logic [3:0] s1_r, s2_r;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_r <= 4'h9;
            s2_r <= 4'h9;
        end else begin
            s1_r <= {ext_reset_n_in, supply_falling_threshold, supply_rising_threshold, serial_receive_line};
            s2_r <= s1_r;
        end
    end
    logic rx_s, rise_s, fall_s, ext_s;
    assign rx_s = s2_r[0];
    assign rise_s = s2_r[1];
    assign fall_s = s2_r[2];
    assign ext_s = s2_r[3];

    // ********************************************************************
    // supply detect with hysteresis and power-on reset timer
    // ********************************************************************
    // supply_falling_threshold high means the supply is above 2.7 V
    logic valid_r, valid_nxt;
    logic por_n_r, por_n_nxt;
    // the counter stops at its end value, so a long good supply cannot wrap it
    logic [31:0] por_cnt_r, por_cnt_nxt;
    always_comb begin
        valid_nxt = valid_r;
        if (!fall_s) begin
            valid_nxt = 1'b0;
        end else if (rise_s) begin
            valid_nxt = 1'b1;
        end
        por_n_nxt = por_n_r;
        por_cnt_nxt = por_cnt_r;
        if (!valid_r) begin
            por_n_nxt = 1'b0;
            por_cnt_nxt = 32'h00000000;
        end else if (!por_n_r) begin
            if (por_cnt_r >= 32'(POR_CYCLES - 1)) begin
                por_n_nxt = 1'b1;
            end else begin
                por_cnt_nxt = por_cnt_r + 32'h00000001;
            end
        end
    end

    // ********************************************************************
    // wired combination and processor reset
    // ********************************************************************
    // the module pulls its own pin low during power-on reset, so the host
    // sees a single shared line and must never drive it high
    assign ext_reset_n_out = 1'b0;
    assign ext_reset_n_oe = !por_n_r;
    logic cpu_run;
    assign cpu_run = por_n_r && ext_s;

    // ********************************************************************
    // settling copy of the power-on reset
    // ********************************************************************
    // the pin reaches the sequencer through two synchroniser stages, so for two
    // cycles after the module lets go of its own pull it still reads low; this
    // copy lags by the same two cycles, so the own pull is not taken for the host
    logic [1:0] por_dly_r, por_dly_nxt;
    always_comb begin
        por_dly_nxt = {por_dly_r[0], por_n_r};
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            por_dly_r <= 2'h0;
        end else begin
            por_dly_r <= por_dly_nxt;
        end
    end

    // ********************************************************************
    // wake-up sequencer
    // ********************************************************************
    typedef enum logic [1:0] {ST_RESET, ST_BOOT, ST_LIVE} rrw_state_t;
    rrw_state_t st_r, st_nxt;
    logic from_ext_r, from_ext_nxt;
    logic [31:0] wcnt_r, wcnt_nxt;
    logic [2:0] rate_r, rate_nxt;
    logic ext_seen_r, ext_seen_nxt;
    always_comb begin
        st_nxt = st_r;
        from_ext_nxt = from_ext_r;
        wcnt_nxt = wcnt_r;
        rate_nxt = rate_r;
        ext_seen_nxt = ext_seen_r;
        // remember whether the last reset was held by the pin while power was good
        // the lagged copy keeps the module's own pull out of this decision
        if (por_dly_r[1] && !ext_s) begin
            ext_seen_nxt = 1'b1;
        end
        unique case (st_r)
            ST_RESET: begin
                // every reset, pin or power, brings the port back to its default rate
                wcnt_nxt = 32'h00000000;
                rate_nxt = rrw_pkg::RATE_RESET;
                if (cpu_run) begin
                    st_nxt = ST_BOOT;
                    from_ext_nxt = ext_seen_r;
                    ext_seen_nxt = 1'b0;
                end
            end
            ST_BOOT: begin
                wcnt_nxt = wcnt_r + 32'h00000001;
                // power-up path counts from the threshold, so subtract the reset hold
                if (from_ext_r ? (wcnt_r >= 32'(WAKE_EXT_CYCLES - 1))
                               : (wcnt_r >= 32'(WAKE_PWR_CYCLES - POR_CYCLES - 1))) begin
                    st_nxt = ST_LIVE;
                end
            end
            ST_LIVE: begin
                // code 7 has no rate behind it and is ignored rather than mapped
                if (rate_load && rate_value < 3'(rrw_pkg::N_RATES)) begin
                    rate_nxt = rate_value;
                end
            end
        endcase
        // either reset source wins over any state and cuts the port at once;
        // a frame in flight is dropped and the line returns to idle high
        if (!cpu_run) begin
            st_nxt = ST_RESET;
        end
    end

    // one register process for sequencer state
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            valid_r <= 1'b0;
            por_n_r <= 1'b0;
            por_cnt_r <= 32'h00000000;
            st_r <= ST_RESET;
            from_ext_r <= 1'b0;
            wcnt_r <= 32'h00000000;
            rate_r <= rrw_pkg::RATE_RESET;
            ext_seen_r <= 1'b0;
        end else begin
            valid_r <= valid_nxt;
            por_n_r <= por_n_nxt;
            por_cnt_r <= por_cnt_nxt;
            st_r <= st_nxt;
            from_ext_r <= from_ext_nxt;
            wcnt_r <= wcnt_nxt;
            rate_r <= rate_nxt;
            ext_seen_r <= ext_seen_nxt;
        end
    end

    // ********************************************************************
    // serial port, gated by the sequencer
    // ********************************************************************
    logic live;
    assign live = (st_r == ST_LIVE);
    // both directions open together: the receiver is never live before the
    // transmitter, so a host that waits for the first output is safe
    rrw_uart u_uart (
        .clock(clock),
        .rst_n(rst_n),
        .tx_en(live),
        .rx_en(live),
        .rate_sel(rate_r),
        .tx_byte(tx_byte),
        .tx_ready(tx_ready),
        .serial_transmit_line(serial_transmit_line),
        .rx_line_sync(rx_s),
        .rx_byte(rx_byte)
    );

    // status is registered state only
    // rx_live mirrors tx_live, kept apart so a later split needs no port change
    assign status = '{por_active: !por_n_r, cpu_in_reset: !cpu_run, tx_live: live, rx_live: live};
endmodule

// ---- rrw_top_monitor.sv ----
// checker: port-level timing and gating checks for the reset and wake-up block
`timescale 1ns/1ps
module rrw_top_monitor #(
    parameter int unsigned POR_CYCLES = 50,
    parameter int unsigned WAKE_PWR_CYCLES = 200,
    parameter int unsigned WAKE_EXT_CYCLES = 150
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // supply and reset pin
    input wire logic supply_rising_threshold,
    input wire logic supply_falling_threshold,
    input wire logic ext_reset_n_in,
    input wire logic ext_reset_n_out,
    input wire logic ext_reset_n_oe,
    // serial and status
    input wire logic serial_transmit_line,
    input wire logic tx_ready,
    input wire rrw_pkg::rrw_byte_t rx_byte,
    input wire rrw_pkg::rrw_status_t status
);
    logic [31:0] sup_cnt_r, sup_cnt_nxt, wake_cnt_r, wake_cnt_nxt;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // counters: cycles of valid supply, cycles from processor release to wake-up
    always_comb begin
        sup_cnt_nxt = (rst_n && supply_rising_threshold && supply_falling_threshold) ? sup_cnt_r + 32'h1 : 32'h0;
        wake_cnt_nxt = (!rst_n || status.cpu_in_reset || status.tx_live) ? 32'h0 : wake_cnt_r + 32'h1;
    end
    always_ff @(posedge clock) begin
        sup_cnt_r <= sup_cnt_nxt;
        wake_cnt_r <= wake_cnt_nxt;
    end
    reset_idle_a: assert property ($rose(rst_n) |-> status == 4'hC && serial_transmit_line)
        else $error("block not idle when reset releases");
    od_low_a: assert property (ext_reset_n_out == 1'b0)
        else $error("reset pin value not low");
    od_por_a: assert property (ext_reset_n_oe == status.por_active)
        else $error("reset pin pull differs from power-on reset");
    por_cpu_a: assert property (status.por_active |-> status.cpu_in_reset)
        else $error("processor free during power-on reset");
    pin_cpu_a: assert property ((!ext_reset_n_in) [*5] |-> status.cpu_in_reset)
        else $error("processor free while reset pin low");
    por_dip_a: assert property ((!supply_falling_threshold) [*5] |-> status.por_active)
        else $error("power-on reset not raised on supply drop");
    por_time_a: assert property ($fell(status.por_active) |-> sup_cnt_r >= POR_CYCLES && sup_cnt_r <= POR_CYCLES + 8)
        else $error("power-on reset hold length wrong");
    wake_time_a: assert property ($rose(status.tx_live) |-> wake_cnt_r <= WAKE_PWR_CYCLES)
        else $error("wake-up later than allowed");
    rx_wake_a: assert property ($rose(status.tx_live) |-> ##[0:2] status.rx_live)
        else $error("receiver not ready with transmitter");
    idle_high_a: assert property ((!status.tx_live) [*2] |-> serial_transmit_line)
        else $error("transmit line low before wake-up");
    ready_gate_a: assert property (tx_ready |-> status.tx_live)
        else $error("transmitter ready before wake-up");
    rx_gate_a: assert property (rx_byte.valid |-> status.rx_live)
        else $error("byte received before wake-up");
    cover property ($fell(status.por_active));
    cover property ($rose(status.tx_live));
    cover property (rx_byte.valid);
endmodule
bind rrw_top rrw_top_monitor #(.POR_CYCLES(POR_CYCLES), .WAKE_PWR_CYCLES(WAKE_PWR_CYCLES),
    .WAKE_EXT_CYCLES(WAKE_EXT_CYCLES)) u_rrw_top_monitor (.*);

// ---- rrw_host_model.sv ----
// host model: open-drain reset driver and serial byte sender
`timescale 1ns/1ps
module rrw_host_model #(
    parameter int unsigned RST_LOW_CYCLES = 80
) (
    // clock
    input wire logic clock,
    // reset wire, open drain with pull-up
    input wire logic dev_pull_n,
    input wire logic dev_oe,
    output logic reset_wire,
    // serial line into the device, pulled up when idle
    output logic rx_line
);
    logic host_pull;
    initial begin
        host_pull = 1'b0;
        rx_line = 1'b1;
    end
    // wired level: either party may only sink the wire
    assign reset_wire = !(host_pull || (dev_oe && !dev_pull_n));
    // hold the wire low, never shorter than the minimum width
    task automatic pulse_reset(input int unsigned n);
        @(posedge clock);
        host_pull <= 1'b1;
        repeat ((n > RST_LOW_CYCLES) ? n : RST_LOW_CYCLES) @(posedge clock);
        host_pull <= 1'b0;
    endtask
    // one 8n1 frame, lsb first, p clock cycles per bit
    task automatic send_byte(input logic [7:0] d, input int unsigned p);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        @(posedge clock);
        for (int i = 0; i < 10; i++) begin
            rx_line <= f[i];
            repeat (p) @(posedge clock);
        end
    endtask
endmodule

// ---- rrw_top_tb.sv ----
// testbench: power-up and pin-reset wake-up, baud rates, gated serial traffic
`timescale 1ns/1ps
module rrw_top_tb;
    localparam int unsigned POR = 50;
    localparam int unsigned WPWR = 200;
    localparam int unsigned WEXT = 150;
    logic clock, rst_n, sup_rise, sup_fall, rate_load, txd, tx_ready, pin_out, pin_oe, pin_wire, rxd;
    logic [2:0] rate_value;
    rrw_pkg::rrw_byte_t tx_byte, rx_byte;
    rrw_pkg::rrw_status_t status;
    int n_fail, tests_run;
    int unsigned txp_q[$];
    logic [7:0] txd_q[$], rx_q[$];
    int unsigned baud[7] = '{4800, 9600, 19200, 38400, 57600, 115200, 230400};
    logic [2:0] rv[7] = '{3'h7, 3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};

    rrw_top #(.POR_CYCLES(POR), .WAKE_PWR_CYCLES(WPWR), .WAKE_EXT_CYCLES(WEXT)) u_rrw_top (
        .clock(clock), .rst_n(rst_n), .supply_rising_threshold(sup_rise), .supply_falling_threshold(sup_fall),
        .ext_reset_n_in(pin_wire), .ext_reset_n_out(pin_out), .ext_reset_n_oe(pin_oe),
        .serial_transmit_line(txd), .serial_receive_line(rxd), .rate_load(rate_load), .rate_value(rate_value),
        .tx_byte(tx_byte), .tx_ready(tx_ready), .rx_byte(rx_byte), .status(status));
    rrw_host_model u_rrw_host_model (.clock(clock), .dev_pull_n(pin_out), .dev_oe(pin_oe),
        .reset_wire(pin_wire), .rx_line(rxd));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // bit period in 125 MHz cycles from the 71.5 MHz divider
    function automatic int unsigned per(input logic [2:0] r);
        per = int'(longint'(rrw_pkg::SYS_HZ / baud[r]) * rrw_pkg::CLK_HZ / rrw_pkg::SYS_HZ);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (e !== g) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // count cycles until the port wakes; bounded so a dead block cannot hang
    task automatic wait_live(output int unsigned n);
        n = 0;
        while (status.tx_live !== 1'b1 && n < 2000) begin
            @(negedge clock);
            n++;
        end
    endtask
    // pin reset by the host; processor must stay held, then wake in time
    task automatic pin_reset(input int unsigned len);
        int unsigned n;
        fork
            u_rrw_host_model.pulse_reset(len);
            begin
                repeat (len - 10) @(negedge clock);
                chk("held by pin", 2'b10, {status.cpu_in_reset, status.tx_live});
            end
        join
        wait_live(n);
        chk("pin wake", 1'b1, n >= WEXT - 5 && n <= WEXT + 10);
    endtask
    // receive watcher: every strobe consumes the oldest expected byte
    always @(negedge clock) begin
        if (rx_byte.valid === 1'b1)
            chk("rx byte", (rx_q.size() > 0) ? {1'b0, rx_q.pop_front()} : 9'h1FF, rx_byte.data);
    end
    // transmit watcher: start-bit width, then data bits 1 to 7 and the stop bit at the 230400 rate
    always begin
        int unsigned p, w;
        logic [8:0] g;
        logic [7:0] d;
        @(negedge txd);
        p = (txp_q.size() > 0) ? txp_q.pop_front() : 0;
        d = (txd_q.size() > 0) ? txd_q.pop_front() : 8'h00;
        w = 0;
        g = 9'h001;
        while (txd === 1'b0 && w < 40000) begin
            @(negedge clock);
            w++;
        end
        chk("start width", 1'b1, w + 3 >= p && w <= p + 3);
        if (p < 600) begin
            for (int j = 1; j < 9; j++) begin
                while (w < (j + 1) * p + p / 2) begin
                    @(negedge clock);
                    w++;
                end
                g[j] = txd;
            end
            chk("tx frame", {1'b1, d}, g);
        end
    end
    initial begin
        repeat (90000) @(posedge clock);
        n_fail++;
        give_verdict();
    end
    // main sequence
    initial begin
        int unsigned n;
        logic [2:0] r;
        logic [7:0] d;
        n_fail = 0;
        tests_run = 0;
        rst_n = 1'b0;
        sup_rise = 1'b0;
        sup_fall = 1'b0;
        rate_load = 1'b0;
        rate_value = 3'h0;
        tx_byte = '0;
        void'($urandom(29));
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        // traffic before wake-up is ignored: nothing is expected
        u_rrw_host_model.send_byte(8'($urandom), per(3'h6));
        @(negedge clock);
        chk("por before supply", 4'hC, status);
        @(posedge clock);
        sup_rise <= 1'b1;
        sup_fall <= 1'b1;
        wait_live(n);
        chk("power wake", 1'b1, n >= WPWR - 5 && n <= WPWR + 10);
        // each rate, a pin reset between them; code 7 is refused
        foreach (rv[i]) begin
            if (i > 0)
                pin_reset(80);
            @(posedge clock);
            rate_load <= 1'b1;
            rate_value <= rv[i];
            @(posedge clock);
            rate_load <= 1'b0;
            r = (rv[i] == 3'h7) ? rrw_pkg::RATE_RESET : rv[i];
            d = (rv[i] == 3'h6) ? (8'($urandom) | 8'h01) : 8'hFF;
            txp_q.push_back(per(r));
            txd_q.push_back(d);
            @(negedge clock);
            chk("ready when live", 1'b1, tx_ready);
            @(posedge clock);
            tx_byte <= {1'b1, d};
            @(posedge clock);
            tx_byte <= '0;
            repeat (((rv[i] == 3'h6) ? 11 : 1) * per(r) + 40) @(posedge clock);
        end
        // host waited for the first output before sending a command
        d = 8'($urandom);
        rx_q.push_back(d);
        u_rrw_host_model.send_byte(d, per(3'h6));
        repeat (100) @(posedge clock);
        chk("rx drained", 0, rx_q.size());
        // supply dip, then the pin held past the power-on reset
        sup_fall <= 1'b0;
        repeat (8) @(negedge clock);
        chk("dip por", 2'b11, {status.por_active, pin_oe});
        @(posedge clock);
        sup_fall <= 1'b1;
        pin_reset(300);
        give_verdict();
    end
endmodule
